/* File: design/standby_pkg.sv */
package standby_pkg;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] MODE_OFS = 4'h4;
	localparam logic [3:0] SETTLE_OFS = 4'h8;
	localparam logic [3:0] STATUS_OFS = 4'hc;
	localparam int TRIG_BIT = 0;
	localparam int MASKABLE_MASK_BIT = 1;
	localparam int FIRST_NMI_MASK_BIT = 2;
	localparam int SECOND_NMI_MASK_BIT = 3;
	localparam logic [2:0] SETTLE_SEL_RST = 3'h6;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] MODE_LIGHT = 2'h0;
	localparam logic [1:0] MODE_DEEP = 2'h1;
	localparam logic [1:0] MODE_STOP = 2'h2;
	localparam logic [1:0] MODE_SUB = 2'h3;
	// Wait is two to the power of this plus the select value
	localparam int SETTLE_BASE_LOG = 10;
	typedef enum logic [2:0] {
		ST_OSC_WAIT, ST_SETTLE, ST_RUN, ST_HALT, ST_LIGHT, ST_DEEP, ST_STOP, ST_SUB
	} state_type;
endpackage

/* File: design/settle_if.sv */
`timescale 1ns/100ps
interface settle_if;
	logic start;
	logic [2:0] select;
	logic done;
	modport ctrl (output start, output select, input done);
	modport timer (input start, input select, output done);
endinterface

/* File: design/settle_timer.sv */
`timescale 1ns/100ps
module settle_timer import standby_pkg::*; #(
	parameter int BASE_LOG = SETTLE_BASE_LOG
) (
	input wire logic i_clk,
	input wire logic i_srst,
	settle_if.timer tif
);
	localparam int CNT_W = BASE_LOG + 8;
	typedef logic [CNT_W-1:0] cnt_type;
	cnt_type cnt_r;
	logic run_r;
	logic done_r;
	wire cnt_type load_val = (cnt_type'(1) << (BASE_LOG + int'(tif.select))) - cnt_type'(1);
	wire last = run_r && (cnt_r == '0);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= last;
			if (tif.start) begin
				cnt_r <= load_val;
				run_r <= 1'b1;
			end else if (last) begin
				run_r <= 1'b0;
			end else if (run_r) begin
				cnt_r <= cnt_r - cnt_type'(1);
			end
		end
	end
	assign tif.done = done_r;
endmodule

/* File: design/standby_mode_control.sv */
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module standby_mode_control import standby_pkg::*; #(
	parameter int SETTLE_LOG = SETTLE_BASE_LOG
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic i_halt_req,
	input wire logic i_nmi0_req,
	input wire logic i_nmi1_req,
	input wire logic i_int_req,
	input wire logic i_osc_running,
	output logic o_cpu_stop,
	output logic o_periph_stop,
	output logic o_osc_stop,
	output logic o_sub_only,
	output logic o_wake
);
	////////////////////////////////////////////////////////////////////////
	state_type state_r, state_nxt;
	logic trig_r;
	logic maskable_mask_r, first_nmi_mask_r, second_nmi_mask_r;
	logic [1:0] mode_r;
	logic [2:0] settle_sel_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic osc_meta_r, osc_sync_r;
	logic cpu_stop_r, periph_stop_r, osc_stop_r, sub_only_r, wake_r;

	settle_if sif();
	settle_timer #(.BASE_LOG(SETTLE_LOG)) u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.tif(sif)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then a single-cycle acknowledge
	wire req = i_read || i_write;
	wire fire_wr = i_write && !wait_r && i_byteenable[0];
	wire wr_ctrl = fire_wr && (i_address == CTRL_OFS);
	wire wr_mode = fire_wr && (i_address == MODE_OFS);
	wire wr_settle = fire_wr && (i_address == SETTLE_OFS);
	wire trig_set = wr_ctrl && i_writedata[TRIG_BIT];
	wire trig_fire = trig_set && (state_r == ST_RUN);
	wire [31:0] ctrl_view = {28'h0, second_nmi_mask_r, first_nmi_mask_r, maskable_mask_r,
		trig_r};
	wire [31:0] status_view = {27'h0, osc_sync_r, 1'b0, state_r};
	wire [31:0] rd_mux = (i_address == CTRL_OFS) ? ctrl_view :
		(i_address == MODE_OFS) ? {30'h0, mode_r} :
		(i_address == SETTLE_OFS) ? {29'h0, settle_sel_r} :
		(i_address == STATUS_OFS) ? status_view : 32'h0;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			wait_r <= !(req && wait_r);
			if (req && wait_r)
				rdata_r <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			trig_r <= 1'b0;
			maskable_mask_r <= 1'b0;
			first_nmi_mask_r <= 1'b0;
			second_nmi_mask_r <= 1'b0;
			mode_r <= MODE_RST;
			settle_sel_r <= SETTLE_SEL_RST;
		end else begin
			// Masks only move on writes that leave the trigger clear
			if (wr_ctrl && !i_writedata[TRIG_BIT]) begin
				maskable_mask_r <= i_writedata[MASKABLE_MASK_BIT];
				first_nmi_mask_r <= i_writedata[FIRST_NMI_MASK_BIT];
				second_nmi_mask_r <= i_writedata[SECOND_NMI_MASK_BIT];
			end
			if (trig_fire)
				trig_r <= 1'b1;
			else if (state_nxt == ST_RUN || state_nxt == ST_OSC_WAIT)
				trig_r <= 1'b0;
			// Upper bits are dropped; software keeps them zero
			if (wr_mode)
				mode_r <= i_writedata[1:0];
			if (wr_settle)
				settle_sel_r <= i_writedata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator status comes from the analog side
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			osc_meta_r <= 1'b0;
			osc_sync_r <= 1'b0;
		end else begin
			osc_meta_r <= i_osc_running;
			osc_sync_r <= osc_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	wire wake_any = i_nmi0_req || i_nmi1_req || i_int_req;
	wire wake_open = (i_nmi0_req && !first_nmi_mask_r) || (i_nmi1_req && !second_nmi_mask_r) ||
		(i_int_req && !maskable_mask_r);
	assign sif.start = (state_r == ST_OSC_WAIT) && osc_sync_r;
	assign sif.select = settle_sel_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OSC_WAIT: begin
				if (osc_sync_r)
					state_nxt = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (sif.done)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (trig_fire) begin
					case (mode_r)
						MODE_LIGHT: state_nxt = ST_LIGHT;
						MODE_DEEP: state_nxt = ST_DEEP;
						MODE_STOP: state_nxt = ST_STOP;
						default: state_nxt = ST_SUB;
					endcase
				end else if (i_halt_req) begin
					state_nxt = ST_HALT;
				end
			end
			ST_HALT: begin
				if (wake_any)
					state_nxt = ST_RUN;
			end
			ST_STOP: begin
				if (wake_open)
					state_nxt = ST_OSC_WAIT;
			end
			default: begin
				if (wake_open)
					state_nxt = ST_RUN;
			end
		endcase
	end

	wire nxt_standby = !(state_nxt == ST_RUN || state_nxt == ST_OSC_WAIT ||
		state_nxt == ST_SETTLE);
	wire cur_standby = !(state_r == ST_RUN || state_r == ST_OSC_WAIT ||
		state_r == ST_SETTLE);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= ST_OSC_WAIT;
			cpu_stop_r <= 1'b1;
			periph_stop_r <= 1'b0;
			osc_stop_r <= 1'b0;
			sub_only_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cpu_stop_r <= state_nxt != ST_RUN;
			periph_stop_r <= state_nxt == ST_DEEP || state_nxt == ST_STOP;
			osc_stop_r <= state_nxt == ST_STOP;
			sub_only_r <= state_nxt == ST_SUB;
			wake_r <= cur_standby && !nxt_standby;
		end
	end

	assign o_readdata = rdata_r;
	assign o_waitrequest = wait_r;
	assign o_cpu_stop = cpu_stop_r;
	assign o_periph_stop = periph_stop_r;
	assign o_osc_stop = osc_stop_r;
	assign o_sub_only = sub_only_r;
	assign o_wake = wake_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_halt_any_wake: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_HALT && wake_any) |=> (state_r == ST_RUN && !o_cpu_stop))
		else $error("halt not released by request");
	a_mask_same_write: assert property (@(posedge i_clk) disable iff (i_srst)
		trig_set |=> (maskable_mask_r == $past(maskable_mask_r) &&
		first_nmi_mask_r == $past(first_nmi_mask_r) &&
		second_nmi_mask_r == $past(second_nmi_mask_r)))
		else $error("mask changed with trigger write");
	a_trigger_gates_mode: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_RUN && !trig_fire) |=> !(state_r inside {ST_LIGHT, ST_DEEP,
		ST_STOP, ST_SUB}))
		else $error("standby entered without trigger");
	a_settle_after_osc: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_OSC_WAIT && !osc_sync_r) |-> !sif.start ##1 (state_r == ST_OSC_WAIT))
		else $error("settle started before oscillator");
	a_stop_to_osc: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_STOP && wake_open) |=> (state_r == ST_OSC_WAIT) ##1 !o_osc_stop)
		else $error("stop release path wrong");
	a_settle_sel_reset: assert property (@(posedge i_clk)
		i_srst |=> (settle_sel_r == SETTLE_SEL_RST && state_r == ST_OSC_WAIT))
		else $error("settle select reset value wrong");
	a_masked_light: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_LIGHT && !wake_open) |=> state_r == ST_LIGHT)
		else $error("masked request released light idle");
	a_pending_halt: assert property (@(posedge i_clk) disable iff (i_srst)
		(state_r == ST_RUN && !trig_fire && i_halt_req) ##1 wake_any |->
		(state_r == ST_HALT && o_cpu_stop) ##1 (state_r == ST_RUN))
		else $error("pending request did not end halt");
	a_mode_code: assert property (@(posedge i_clk) disable iff (i_srst)
		(trig_fire && mode_r == MODE_STOP) |=> (state_r == ST_STOP && o_osc_stop))
		else $error("mode code mapping wrong");
	a_bus_answer: assert property (@(posedge i_clk) disable iff (i_srst)
		(req && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer timing wrong");
	c_light_cycle: cover property (@(posedge i_clk) disable iff (i_srst)
		state_r == ST_LIGHT ##[1:50] state_r == ST_RUN);
	c_stop_cycle: cover property (@(posedge i_clk) disable iff (i_srst)
		state_r == ST_STOP ##1 state_r == ST_OSC_WAIT ##[1:100] state_r == ST_SETTLE);
	c_halt_cycle: cover property (@(posedge i_clk) disable iff (i_srst)
		state_r == ST_HALT ##1 state_r == ST_RUN);
	c_sub_entry: cover property (@(posedge i_clk) disable iff (i_srst)
		trig_fire && mode_r == MODE_SUB);
endmodule

/* File: bench/standby_mode_control_tb.sv */
`timescale 1ns/100ps
module standby_mode_control_tb import standby_pkg::*;;
	logic i_clk = 0, i_srst = 1, i_read = 0, i_write = 0;
	logic [3:0] i_address = 4'h0, i_byteenable = 4'hf;
	logic [31:0] i_writedata = 32'h0, o_readdata, d;
	logic o_waitrequest, o_cpu_stop, o_periph_stop, o_osc_stop, o_sub_only, o_wake;
	logic i_halt_req = 0, i_nmi0_req = 0, i_nmi1_req = 0, i_int_req = 0, i_osc_running = 0;
	logic [3:0] exp_out [4] = '{4'h8, 4'hc, 4'he, 4'h9};
	int miscompares = 0, n_tests = 0, cnt;
	// Small exponent keeps the settle wait at 256 cycles for select 6
	standby_mode_control #(.SETTLE_LOG(2)) standby_mode_control_inst (.i_clk(i_clk),
		.i_srst(i_srst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_halt_req(i_halt_req), .i_nmi0_req(i_nmi0_req),
		.i_nmi1_req(i_nmi1_req), .i_int_req(i_int_req), .i_osc_running(i_osc_running),
		.o_cpu_stop(o_cpu_stop), .o_periph_stop(o_periph_stop), .o_osc_stop(o_osc_stop),
		.o_sub_only(o_sub_only), .o_wake(o_wake));
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_address <= a;
		i_writedata <= v;
		i_write <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		i_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_address <= a;
		i_read <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		v = o_readdata;
		i_read <= 1'b0;
	endtask
	task automatic wait_wake();
		cnt = 0;
		do begin
			@(posedge i_clk);
			cnt++;
		end while (o_wake !== 1'b1 && cnt < 50);
		chk({31'h0, o_wake}, 32'h1);
	endtask
	// Counts cycles from oscillator start until the core runs again
	task automatic osc_start_and_count();
		repeat (40) @(posedge i_clk);
		chk({31'h0, o_cpu_stop}, 32'h1);
		i_osc_running <= 1'b1;
		cnt = 0;
		do begin
			@(posedge i_clk);
			cnt++;
		end while (o_cpu_stop !== 1'b0 && cnt < 2000);
		chk({31'h0, (cnt >= 256 && cnt <= 262)}, 32'h1);
	endtask
	task automatic status(input logic [2:0] st);
		rd(STATUS_OFS, d);
		chk({29'h0, d[2:0]}, {29'h0, st});
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge i_clk);
		i_srst <= 1'b0;
		osc_start_and_count();
		rd(SETTLE_OFS, d);
		chk({29'h0, d[2:0]}, {29'h0, SETTLE_SEL_RST});
		// Halt ignores all three masks and leaves at once on a pending request
		wr(CTRL_OFS, 32'he);
		i_int_req <= 1'b1;
		@(posedge i_clk);
		i_halt_req <= 1'b1;
		@(posedge i_clk);
		i_halt_req <= 1'b0;
		wait_wake();
		status(ST_RUN);
		// Mask set together with the trigger must not hold off the wake
		wr(CTRL_OFS, 32'h0);
		wr(MODE_OFS, {30'h0, MODE_LIGHT});
		wr(CTRL_OFS, 32'h3);
		wait_wake();
		rd(CTRL_OFS, d);
		chk({28'h0, d[3:0]}, 32'h0);
		// Every mode, entered with the pending request masked beforehand
		wr(CTRL_OFS, 32'he);
		for (int m = 0; m < 4; m++) begin
			wr(MODE_OFS, m);
			status(ST_RUN);
			wr(CTRL_OFS, 32'h1);
			repeat (4) @(posedge i_clk);
			status(3'(4 + m));
			chk({28'h0, o_cpu_stop, o_periph_stop, o_osc_stop, o_sub_only},
				{28'h0, exp_out[m]});
			if (m == 2) begin
				i_osc_running <= 1'b0;
			end
			wr(CTRL_OFS, 32'h0);
			wait_wake();
			if (m == 2) begin
				osc_start_and_count();
			end
			repeat (2) @(posedge i_clk);
			status(ST_RUN);
			wr(CTRL_OFS, 32'he);
		end
		// Unmasked nonmaskable request releases light idle
		wr(MODE_OFS, {30'h0, MODE_LIGHT});
		wr(CTRL_OFS, 32'h1);
		wr(CTRL_OFS, 32'ha);
		i_nmi0_req <= 1'b1;
		wait_wake();
		i_nmi0_req <= 1'b0;
		// Second nonmaskable request held off by its mask, then let through
		wr(CTRL_OFS, 32'h1);
		i_nmi1_req <= 1'b1;
		repeat (4) @(posedge i_clk);
		status(ST_LIGHT);
		wr(CTRL_OFS, 32'h2);
		wait_wake();
		i_nmi1_req <= 1'b0;
		// Write without lane 0 leaves the control register alone
		i_byteenable <= 4'he;
		wr(CTRL_OFS, 32'hc);
		i_byteenable <= 4'hf;
		rd(CTRL_OFS, d);
		chk(d, 32'h2);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		final_report();
	end
endmodule
